// >>> logic/dio_port_pkg.sv
/*
  package for the sixteen-line digital port with timer multiplexing:
  line count, reset values, function-select encodings and the carrier structs.
  assumes nothing of its surroundings; used by dio_port and the testbench.
*/
`default_nettype none

package dio_port_pkg;

  localparam int unsigned LINE_COUNT = 16;

  // function select after reset: plain general-purpose use
  localparam logic [1:0] FUNC_GPIO     = 2'h0;
  localparam logic [1:0] FUNC_TIMER4   = 2'h1;
  localparam logic [1:0] FUNC_TIMER8   = 2'h2;
  localparam logic [1:0] FUNC_RESET    = 2'h0;

  localparam logic [15:0] DIR_RESET    = 16'h0000;
  localparam logic [15:0] INVERT_RESET = 16'h0000;
  localparam logic [15:0] LEVEL_RESET  = 16'h0000;

  // zero-based line positions of the timer signals
  localparam int unsigned LINE_CH5_OUT_A = 8;
  localparam int unsigned LINE_CH5_OUT_B = 9;
  localparam int unsigned LINE_CH3_GATE  = 10;
  localparam int unsigned LINE_CH4_GATE  = 11;
  localparam int unsigned LINE_T3_OUT    = 12;
  localparam int unsigned LINE_T3_IN     = 13;
  localparam int unsigned LINE_T4_OUT    = 14;
  localparam int unsigned LINE_T4_IN     = 15;

  typedef struct packed {
    logic t3_out;
    logic t4_out;
    logic ch5_out;
  } timer_out_type;

  typedef struct packed {
    logic t3_in;
    logic t4_in;
    logic ch3_gate;
    logic ch4_gate;
  } timer_in_type;

endpackage : dio_port_pkg

`default_nettype wire

// >>> logic/dio_port.sv
/*
  sixteen-line general-purpose port with optional timer signals on lines 9-16.
  assumes pin inputs synchronous to clk, an external pull-up on every line,
  and control bits held by surrounding logic as plain ports.
*/
`default_nettype none
`timescale 1ns/1ps

module dio_port #(
  parameter int unsigned LINES = dio_port_pkg::LINE_COUNT
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic [LINES-1:0]            dir_out,
  input  wire logic [LINES-1:0]            invert_in,
  input  wire logic [LINES-1:0]            out_level,
  input  wire logic [1:0]                  func_sel,
  input  wire dio_port_pkg::timer_out_type timer_out,
  input  wire logic [LINES-1:0]            line_in,
  output var  logic [LINES-1:0]            line_out,
  output var  logic [LINES-1:0]            line_oe,
  output var  logic [LINES-1:0]            read_value,
  output var  dio_port_pkg::timer_in_type  timer_in,
  output var  logic [1:0]                  func_mode
);

  // the timer line positions are fixed, so any other width cannot be served
  if (LINES != dio_port_pkg::LINE_COUNT) begin : g_bad_lines
    $error("dio_port serves exactly sixteen lines");
  end

  // ==========================================================
  // function select register
  logic [1:0] next_func_mode;

  always_comb begin
    next_func_mode = func_mode;
    if (func_sel == dio_port_pkg::FUNC_GPIO || func_sel == dio_port_pkg::FUNC_TIMER4 ||
        func_sel == dio_port_pkg::FUNC_TIMER8) begin
      next_func_mode = func_sel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_mode <= dio_port_pkg::FUNC_RESET;
    end else if (clk_en) begin
      func_mode <= next_func_mode;
    end
  end

  // ==========================================================
  // per-line ownership: which lines the timers claim, and how
  logic [LINES-1:0] timer_owned;
  logic [LINES-1:0] timer_drives;
  logic [LINES-1:0] timer_level;
  logic             mode4;
  logic             mode8;

  always_comb begin
    mode4 = (func_mode == dio_port_pkg::FUNC_TIMER4) || (func_mode == dio_port_pkg::FUNC_TIMER8);
    mode8 = (func_mode == dio_port_pkg::FUNC_TIMER8);
    timer_owned  = '0;
    timer_drives = '0;
    timer_level  = '0;
    timer_owned[dio_port_pkg::LINE_T3_OUT]  = mode4;
    timer_owned[dio_port_pkg::LINE_T3_IN]   = mode4;
    timer_owned[dio_port_pkg::LINE_T4_OUT]  = mode4;
    timer_owned[dio_port_pkg::LINE_T4_IN]   = mode4;
    timer_owned[dio_port_pkg::LINE_CH5_OUT_A] = mode8;
    timer_owned[dio_port_pkg::LINE_CH5_OUT_B] = mode8;
    timer_owned[dio_port_pkg::LINE_CH3_GATE]  = mode8;
    timer_owned[dio_port_pkg::LINE_CH4_GATE]  = mode8;
    timer_drives[dio_port_pkg::LINE_T3_OUT] = mode4;
    timer_drives[dio_port_pkg::LINE_T4_OUT] = mode4;
    timer_drives[dio_port_pkg::LINE_CH5_OUT_A] = mode8;
    timer_drives[dio_port_pkg::LINE_CH5_OUT_B] = mode8;
    timer_level[dio_port_pkg::LINE_T3_OUT] = timer_out.t3_out;
    timer_level[dio_port_pkg::LINE_T4_OUT] = timer_out.t4_out;
    timer_level[dio_port_pkg::LINE_CH5_OUT_A] = timer_out.ch5_out;
    timer_level[dio_port_pkg::LINE_CH5_OUT_B] = timer_out.ch5_out;
  end

  // ==========================================================
  // line drivers and read-back
  // a timer output still needs its direction bit set, so software keeps the
  // final say over whether anything drives the connector
  logic [LINES-1:0] next_line_out;
  logic [LINES-1:0] next_line_oe;
  logic [LINES-1:0] next_read_value;

  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      next_line_oe[i]  = dir_out[i] & (~timer_owned[i] | timer_drives[i]);
      next_line_out[i] = timer_drives[i] ? timer_level[i] : out_level[i];
      next_read_value[i] = line_in[i] ^ invert_in[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_oe    <= dio_port_pkg::DIR_RESET;
      line_out   <= dio_port_pkg::LEVEL_RESET;
      read_value <= dio_port_pkg::INVERT_RESET;
    end else if (clk_en) begin
      line_oe    <= next_line_oe;
      line_out   <= next_line_out;
      read_value <= next_read_value;
    end
  end

  // ==========================================================
  // timer inputs taken from the pins
  dio_port_pkg::timer_in_type next_timer_in;

  always_comb begin
    next_timer_in.t3_in    = mode4 & line_in[dio_port_pkg::LINE_T3_IN];
    next_timer_in.t4_in    = mode4 & line_in[dio_port_pkg::LINE_T4_IN];
    next_timer_in.ch3_gate = mode8 & line_in[dio_port_pkg::LINE_CH3_GATE];
    next_timer_in.ch4_gate = mode8 & line_in[dio_port_pkg::LINE_CH4_GATE];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_in <= '0;
    end else if (clk_en) begin
      timer_in <= next_timer_in;
    end
  end

  // ==========================================================
  // checks
  a_reset_released: assert property (@(posedge clk) $rose(rst_n) |-> line_oe == '0)
    else $error("drivers not released after reset");

  a_dir_follows: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && func_mode == dio_port_pkg::FUNC_GPIO |=> line_oe == $past(dir_out))
    else $error("direction not followed in plain mode");

  a_invert_read: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> read_value == ($past(line_in) ^ $past(invert_in)))
    else $error("read-back polarity wrong");

  a_level_drive: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && func_mode == dio_port_pkg::FUNC_GPIO |=> line_out == $past(out_level))
    else $error("output level wrong");

  a_mode_default: assert property (@(posedge clk) $rose(rst_n) |-> func_mode == dio_port_pkg::FUNC_RESET)
    else $error("function select not plain after reset");

  a_mode4_span: assert property (@(posedge clk) disable iff (!rst_n)
    func_mode == dio_port_pkg::FUNC_TIMER4 |-> timer_owned == 16'hF000)
    else $error("four-signal mode claims wrong lines");

  // a timer mode that has been in force for one enabled edge already owns its pins
  sequence s_mode4_held;
    clk_en && mode4 && $stable(func_mode) ##1 clk_en;
  endsequence

  a_t3_out_pin: assert property (@(posedge clk) disable iff (!rst_n)
    s_mode4_held |->
    line_out[dio_port_pkg::LINE_T3_OUT] == $past(timer_out.t3_out))
    else $error("timer 3 output not on line 13");

  a_t4_out_pin: assert property (@(posedge clk) disable iff (!rst_n)
    s_mode4_held |->
    line_out[dio_port_pkg::LINE_T4_OUT] == $past(timer_out.t4_out))
    else $error("timer 4 output not on line 15");

  a_t4_in_pin: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mode4 |=> timer_in.t4_in == $past(line_in[dio_port_pkg::LINE_T4_IN]))
    else $error("timer 4 input not taken from line 16");

  a_mode8_span: assert property (@(posedge clk) disable iff (!rst_n)
    func_mode == dio_port_pkg::FUNC_TIMER8 |-> timer_owned == 16'hFF00)
    else $error("eight-signal mode claims wrong lines");

  a_ch5_pins: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mode8 |=> line_out[dio_port_pkg::LINE_CH5_OUT_A] == $past(timer_out.ch5_out) &&
    line_out[dio_port_pkg::LINE_CH5_OUT_B] == $past(timer_out.ch5_out))
    else $error("channel 5 output not on lines 9 and 10");

  a_gate3_pin: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mode8 |=> timer_in.ch3_gate == $past(line_in[dio_port_pkg::LINE_CH3_GATE]))
    else $error("channel 3 gate not taken from line 11");

  a_mode_select: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && func_sel != 2'h3 |=> func_mode == $past(func_sel))
    else $error("function select not taken");

  a_input_only: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en |=> (line_oe & ~$past(dir_out)) == '0)
    else $error("input line driven");

  // a low enable must hold every output, or a stalled host would see pins move
  a_enable_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(line_oe) && $stable(line_out) && $stable(read_value) && $stable(func_mode))
    else $error("state moved while enable low");

  a_gate_pin: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && func_mode != dio_port_pkg::FUNC_TIMER8 |=> !timer_in.ch3_gate && !timer_in.ch4_gate)
    else $error("gate input passed outside eight-signal mode");

  a_input_released: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && mode4 |=> !line_oe[dio_port_pkg::LINE_T3_IN] && !line_oe[dio_port_pkg::LINE_T4_IN])
    else $error("timer input line driven");

endmodule : dio_port

`default_nettype wire

// >>> dv/dio_equipment.sv
/*
  model of the equipment on the i/o connector: pull-up on every line,
  optional drive of released lines. assumes oe is high while the port drives.
*/
`timescale 1ns/1ps
`default_nettype none

module dio_equipment (
  input  wire logic [15:0] line_oe,
  input  wire logic [15:0] line_out,
  input  wire logic [15:0] ext_en,
  input  wire logic [15:0] ext_drive,
  output var  logic [15:0] line_in
);
  // ===========================================================
  // wire resolution
  // the equipment yields whenever the port drives, so no contention is modelled
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (line_oe[i]) line_in[i] = line_out[i];
      else if (ext_en[i]) line_in[i] = ext_drive[i];
      else line_in[i] = 1'b1;
    end
  end
endmodule : dio_equipment

`default_nettype wire

// >>> dv/test_digital_io_port_timer_mux.sv
/*
  testbench for the digital port: drives controls at the falling edge, checks pins.
  assumes dio_port and dio_equipment are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none

module test_digital_io_port_timer_mux;
  logic                        clk, rst_n, clk_en;
  logic [15:0]                 dir_out, invert_in, out_level, ext_en, ext_drive;
  logic [15:0]                 line_in, line_out, line_oe, read_value;
  logic [1:0]                  func_sel, func_mode;
  dio_port_pkg::timer_out_type timer_out;
  dio_port_pkg::timer_in_type  timer_in;
  int                          n_fail, checked;

  dio_port i_dio_port (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .dir_out(dir_out), .invert_in(invert_in),
    .out_level(out_level), .func_sel(func_sel), .timer_out(timer_out), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .read_value(read_value), .timer_in(timer_in), .func_mode(func_mode));
  dio_equipment i_dio_equipment (.line_oe(line_oe), .line_out(line_out), .ext_en(ext_en),
    .ext_drive(ext_drive), .line_in(line_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ===========================================================
  // tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // three edges: mode lands on the first, pins on the second, timer inputs by the third
  task automatic setup(input logic [15:0] d, l, e, x, input logic [1:0] f, input logic [2:0] t);
    @(negedge clk);
    dir_out = d;
    out_level = l;
    ext_en = e;
    ext_drive = x;
    func_sel = f;
    timer_out = dio_port_pkg::timer_out_type'(t);
    repeat (3) @(negedge clk);
  endtask : setup

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // ===========================================================
  // main sequence
  initial begin
    {rst_n, dir_out, invert_in, out_level, ext_en, ext_drive, func_sel} = '0;
    timer_out = dio_port_pkg::timer_out_type'(3'h0);
    clk_en = 1'b1;
    repeat (12) @(negedge clk);
    check(line_oe, 16'h0000, "oe in reset");
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    check(line_oe, 16'h0000, "oe after reset");
    check(read_value, 16'hFFFF, "pulled-up read");
    check({14'h0000, func_mode}, 16'h0000, "mode after reset");
    $display("test reset done");
    invert_in = 16'hFF00;
    setup(16'hA5A5, 16'h0F0F, 16'h5A5A, 16'h1234, 2'h0, 3'h0);
    check(line_oe, 16'hA5A5, "per-line direction");
    check(line_out & line_oe, 16'h0505, "driven levels");
    check(read_value, 16'h0505 ^ 16'h1210 ^ 16'hFF00, "inverted read");
    $display("test plain lines done");
    invert_in = 16'h0000;
    setup(16'hFFFF, 16'h0000, 16'hA000, 16'h2000, 2'h1, 3'h5);
    check({14'h0000, func_mode}, 16'h0001, "four-signal mode");
    check(line_oe, 16'h5FFF, "timer inputs released");
    check(line_out & line_oe, 16'h1000, "timer outputs");
    check({12'h000, timer_in}, 16'h0008, "timer inputs");
    setup(16'hFFFF, 16'h0000, 16'hAC00, 16'h2800, 2'h2, 3'h5);
    check(line_oe, 16'h53FF, "gates released");
    check(line_out & line_oe, 16'h1300, "channel 5 outputs");
    check({12'h000, timer_in}, 16'h0009, "gate inputs");
    setup(16'hFFFF, 16'h0000, 16'hAC00, 16'h2800, 2'h3, 3'h5);
    check({14'h0000, func_mode}, 16'h0002, "unused code keeps mode");
    setup(16'hFFFF, 16'h0000, 16'hAC00, 16'h8400, 2'h2, 3'h6);
    check(line_out & line_oe, 16'h5000, "timer 4 output");
    check({12'h000, timer_in}, 16'h0006, "timer 4 input and gate 3");
    setup(16'hFFFF, 16'h0000, 16'h0000, 16'h0000, 2'h0, 3'h5);
    check(line_oe, 16'hFFFF, "back to plain");
    check({12'h000, timer_in}, 16'h0000, "timer inputs idle");
    clk_en = 1'b0;
    dir_out = 16'h0000;
    repeat (2) @(negedge clk);
    check(line_oe, 16'hFFFF, "enable low freezes");
    clk_en = 1'b1;
    @(negedge clk);
    check(line_oe, 16'h0000, "enable high resumes");
    $display("test timer modes done");
    final_report();
  end
endmodule : test_digital_io_port_timer_mux

`default_nettype wire
